// ==== include/lcd_seg_pkg.sv ====
`default_nettype none
package lcd_seg_pkg;
    timeunit 1ns;
    timeprecision 1ns;
    // Glass geometry
    localparam int SEG_N        = 40;
    localparam int COM_N        = 4;
    localparam int DM_BYTES     = 21;
    localparam int DM_ROW_BYTES = 5;
    localparam int DM_WORDS     = 6;
    localparam int FDIV_W       = 16;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_FDIV     = 8'h04;
    localparam logic [7:0] REG_GPEN_LO  = 8'h08;
    localparam logic [7:0] REG_GPEN_HI  = 8'h0c;
    localparam logic [7:0] REG_GPOUT_LO = 8'h10;
    localparam logic [7:0] REG_GPOUT_HI = 8'h14;
    localparam logic [7:0] REG_STATUS   = 8'h18;
    localparam logic [7:0] REG_DM_BASE  = 8'h20;
    localparam logic [7:0] REG_DM_LAST  = 8'h34;

    // Control field positions
    localparam int CTRL_EN     = 0;
    localparam int CTRL_MODE   = 1;
    localparam int CTRL_SIZE   = 3;
    localparam int CTRL_CLKSEL = 5;
    localparam int CTRL_W      = 6;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
    localparam logic [FDIV_W-1:0] FDIV_RST = 16'h00ff;

    typedef enum logic [1:0] {
        MODE_STATIC  = 2'h0,
        MODE_HALF    = 2'h1,
        MODE_THIRD   = 2'h2,
        MODE_QUARTER = 2'h3
    } mode_t;

    typedef enum logic [1:0] {
        SIZE_24 = 2'h0,
        SIZE_32 = 2'h1,
        SIZE_40 = 2'h2
    } size_t;

    localparam logic [5:0] SEGS_24 = 6'h18;
    localparam logic [5:0] SEGS_32 = 6'h20;
    localparam logic [5:0] SEGS_40 = 6'h28;

    // Drive level codes: 0, 1/3 (or 1/2), 2/3, full drive voltage
    typedef enum logic [1:0] {
        LVL_0 = 2'h0,
        LVL_1 = 2'h1,
        LVL_2 = 2'h2,
        LVL_3 = 2'h3
    } lvl_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SCAN = 2'b10
    } scan_t;

    typedef struct packed {
        logic [SEG_N-1:0][1:0] seg;
        logic [COM_N-1:0][1:0] com;
        logic                  bias_half;
    } lcd_drive_t;

    typedef struct packed {
        logic [SEG_N-1:0] en;
        logic [SEG_N-1:0] out;
    } seg_gpio_t;
endpackage : lcd_seg_pkg
`default_nettype wire

// ==== hw/lcd_segment_drive_controller.sv ====
// Operation
// - Forty segment and four common outputs multiplexed
// - Unused segment pins released as GPIO
// - Software sets each segment bit in display memory
// - Display memory scanned automatically at frame rate
// - Segment lit only with its common selected
// - Static, half, third, quarter duty modes
// - Half duty half bias; third and quarter duty third bias
// - Selectable scan clock, adjustable frame frequency
// - Capacity of 24, 32 or 40 segment lines
`default_nettype none
module lcd_segment_drive_controller
(
    input  wire logic                   sys_clk,
    input  wire logic                   arst_n,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    input  wire logic                   lcd_ext_clk,
    output lcd_seg_pkg::lcd_drive_t     lcd_drive,
    output lcd_seg_pkg::seg_gpio_t      seg_gpio
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [lcd_seg_pkg::CTRL_W-1:0] ctrl_r;
    logic [lcd_seg_pkg::FDIV_W-1:0] fdiv_r;
    logic [lcd_seg_pkg::SEG_N-1:0]  gpen_r;
    logic [lcd_seg_pkg::SEG_N-1:0]  gpout_r;
    logic [7:0]                     dm_r [0:lcd_seg_pkg::DM_BYTES-1];
    logic                           wr_pend_r;
    logic [7:0]                     wr_addr_r;
    logic                           rd_pend_r;
    logic [7:0]                     rd_addr_r;
    logic                           ext_s1_r;
    logic                           ext_s2_r;
    logic                           ext_s3_r;
    lcd_seg_pkg::scan_t             state_r;
    logic [lcd_seg_pkg::FDIV_W-1:0] div_r;
    logic [1:0]                     com_idx_r;
    logic                           pol_r;
    logic                           accept;
    logic                           src_pulse;
    logic                           phase_end;
    logic                           en;
    lcd_seg_pkg::mode_t             mode;
    lcd_seg_pkg::size_t             size;
    logic [5:0]                     seg_cnt;
    logic [4:0]                     row_base;
    logic [lcd_seg_pkg::SEG_N-1:0]  row_bits;
    lcd_seg_pkg::lcd_drive_t        drive_nxt;
    logic [lcd_seg_pkg::SEG_N-1:0]  gpio_en_nxt;
    logic [31:0]                    rd_nxt;
    assign en     = ctrl_r[lcd_seg_pkg::CTRL_EN];
    assign mode   = lcd_seg_pkg::mode_t'(ctrl_r[lcd_seg_pkg::CTRL_MODE+:2]);
    assign size   = lcd_seg_pkg::size_t'(ctrl_r[lcd_seg_pkg::CTRL_SIZE+:2]);
    assign accept = hsel & htrans[1] & hready;
    // Bus address phase capture
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rd_addr_r <= 8'h00;
        end
        else
        begin
            wr_pend_r <= accept & hwrite;
            rd_pend_r <= accept & ~hwrite;
            if (accept)
            begin
                wr_addr_r <= haddr[7:0];
                rd_addr_r <= haddr[7:0];
            end
        end
    end
    // One wait state on reads so they see a write just committed
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end
        else
        begin
            hreadyout <= ~(accept & ~hwrite);
            hresp     <= 1'b0;
            if (rd_pend_r)
            begin
                hrdata <= rd_nxt;
            end
        end
    end
    // Register read mux, unmapped reads zero
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        unique case (rd_addr_r)
            lcd_seg_pkg::REG_CTRL:     rd_nxt[lcd_seg_pkg::CTRL_W-1:0] = ctrl_r;
            lcd_seg_pkg::REG_FDIV:     rd_nxt[lcd_seg_pkg::FDIV_W-1:0] = fdiv_r;
            lcd_seg_pkg::REG_GPEN_LO:  rd_nxt = gpen_r[31:0];
            lcd_seg_pkg::REG_GPEN_HI:  rd_nxt[7:0] = gpen_r[39:32];
            lcd_seg_pkg::REG_GPOUT_LO: rd_nxt = gpout_r[31:0];
            lcd_seg_pkg::REG_GPOUT_HI: rd_nxt[7:0] = gpout_r[39:32];
            lcd_seg_pkg::REG_STATUS:   rd_nxt[4:0] = {state_r == lcd_seg_pkg::ST_SCAN, lcd_drive.bias_half,
                                                      pol_r, com_idx_r};
            default:
            begin
                if (rd_addr_r >= lcd_seg_pkg::REG_DM_BASE && rd_addr_r <= lcd_seg_pkg::REG_DM_LAST)
                begin
                    for (int b = 0; b < 4; b++)
                    begin
                        if ((rd_addr_r[4:2] * 4 + b) < lcd_seg_pkg::DM_BYTES)
                        begin
                            rd_nxt[b*8+:8] = dm_r[rd_addr_r[4:2]*4+b];
                        end
                    end
                end
            end
        endcase
    end
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_r  <= lcd_seg_pkg::CTRL_RST;
            fdiv_r  <= lcd_seg_pkg::FDIV_RST;
            gpen_r  <= '0;
            gpout_r <= '0;
        end
        else if (wr_pend_r)
        begin
            unique case (wr_addr_r)
                lcd_seg_pkg::REG_CTRL:     ctrl_r <= hwdata[lcd_seg_pkg::CTRL_W-1:0];
                lcd_seg_pkg::REG_FDIV:     fdiv_r <= hwdata[lcd_seg_pkg::FDIV_W-1:0];
                lcd_seg_pkg::REG_GPEN_LO:  gpen_r[31:0] <= hwdata;
                lcd_seg_pkg::REG_GPEN_HI:  gpen_r[39:32] <= hwdata[7:0];
                lcd_seg_pkg::REG_GPOUT_LO: gpout_r[31:0] <= hwdata;
                lcd_seg_pkg::REG_GPOUT_HI: gpout_r[39:32] <= hwdata[7:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < lcd_seg_pkg::DM_BYTES; i++)
            begin
                dm_r[i] <= 8'h00;
            end
        end
        else if (wr_pend_r && wr_addr_r >= lcd_seg_pkg::REG_DM_BASE && wr_addr_r <= lcd_seg_pkg::REG_DM_LAST)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if ((wr_addr_r[4:2] * 4 + b) < lcd_seg_pkg::DM_BYTES)
                begin
                    dm_r[wr_addr_r[4:2]*4+b] <= hwdata[b*8+:8];
                end
            end
        end
    end
    // External scan clock synchroniser
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end
        else
        begin
            ext_s1_r <= lcd_ext_clk;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end
    assign src_pulse = ctrl_r[lcd_seg_pkg::CTRL_CLKSEL] ? (ext_s2_r & ~ext_s3_r) : 1'b1;
    assign phase_end = src_pulse && (div_r == fdiv_r);
    // Scan sequencer
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r   <= lcd_seg_pkg::ST_IDLE;
            div_r     <= '0;
            com_idx_r <= 2'h0;
            pol_r     <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                lcd_seg_pkg::ST_IDLE:
                begin
                    div_r     <= '0;
                    com_idx_r <= 2'h0;
                    pol_r     <= 1'b0;
                    if (en)
                    begin
                        state_r <= lcd_seg_pkg::ST_SCAN;
                    end
                end
                lcd_seg_pkg::ST_SCAN:
                begin
                    if (!en)
                    begin
                        state_r <= lcd_seg_pkg::ST_IDLE;
                    end
                    else if (phase_end)
                    begin
                        div_r <= '0;
                        if (com_idx_r >= mode)
                        begin
                            com_idx_r <= 2'h0;
                            pol_r     <= ~pol_r;
                        end
                        else
                        begin
                            com_idx_r <= com_idx_r + 2'h1;
                        end
                    end
                    else if (src_pulse)
                    begin
                        div_r <= div_r + 16'h0001;
                    end
                end
            endcase
        end
    end
    assign row_base = 5'({com_idx_r, 2'h0}) + 5'(com_idx_r);
    always_comb
    begin
        row_bits = '0;
        for (int b = 0; b < lcd_seg_pkg::DM_ROW_BYTES; b++)
        begin
            row_bits[b*8+:8] = dm_r[row_base+5'(b)];
        end
    end
    assign seg_cnt = (size == lcd_seg_pkg::SIZE_24) ? lcd_seg_pkg::SEGS_24 :
                     (size == lcd_seg_pkg::SIZE_32) ? lcd_seg_pkg::SEGS_32 :
                     lcd_seg_pkg::SEGS_40;
    assign drive_nxt.bias_half = (mode == lcd_seg_pkg::MODE_HALF);
    for (genvar s = 0; s < lcd_seg_pkg::SEG_N; s++)
    begin : g_seg
        always_comb
        begin
            if (state_r != lcd_seg_pkg::ST_SCAN)
                drive_nxt.seg[s] = lcd_seg_pkg::LVL_0;
            else if (row_bits[s])
                drive_nxt.seg[s] = pol_r ? lcd_seg_pkg::LVL_0 : lcd_seg_pkg::LVL_3;
            else if (mode >= lcd_seg_pkg::MODE_THIRD)
                drive_nxt.seg[s] = pol_r ? lcd_seg_pkg::LVL_2 : lcd_seg_pkg::LVL_1;
            else
                drive_nxt.seg[s] = pol_r ? lcd_seg_pkg::LVL_3 : lcd_seg_pkg::LVL_0;
        end
        assign gpio_en_nxt[s] = gpen_r[s] | (6'(s) >= seg_cnt);
    end
    for (genvar c = 0; c < lcd_seg_pkg::COM_N; c++)
    begin : g_com
        always_comb
        begin
            if (state_r != lcd_seg_pkg::ST_SCAN || 2'(c) > mode)
                drive_nxt.com[c] = lcd_seg_pkg::LVL_0;
            else if (2'(c) == com_idx_r)
                drive_nxt.com[c] = pol_r ? lcd_seg_pkg::LVL_3 : lcd_seg_pkg::LVL_0;
            else if (mode == lcd_seg_pkg::MODE_HALF)
                drive_nxt.com[c] = lcd_seg_pkg::LVL_1;
            else
                drive_nxt.com[c] = pol_r ? lcd_seg_pkg::LVL_1 : lcd_seg_pkg::LVL_2;
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lcd_drive <= '0;
            seg_gpio  <= '0;
        end
        else
        begin
            lcd_drive    <= drive_nxt;
            seg_gpio.en  <= gpio_en_nxt;
            seg_gpio.out <= gpout_r;
        end
    end
endmodule : lcd_segment_drive_controller
`default_nettype wire

// ==== dv/lcd_glass_model.sv ====
`default_nettype none
module lcd_glass_model
(
    input wire lcd_seg_pkg::lcd_drive_t lcd_drive,
    output logic [3:0][39:0]            lit
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pair lights only at full voltage across it
    always_comb
        for (int c = 0; c < 4; c++)
            for (int s = 0; s < 40; s++)
                lit[c][s] = {lcd_drive.seg[s], lcd_drive.com[c]} inside {4'hc, 4'h3};
endmodule : lcd_glass_model
`default_nettype wire

// ==== dv/lcd_segment_drive_controller_assertions.sv ====
`default_nettype none
module lcd_seg_checker
(
    input wire logic                    sys_clk,
    input wire logic                    arst_n,
    input wire logic                    hsel,
    input wire logic [1:0]              htrans,
    input wire logic                    hwrite,
    input wire logic                    hready,
    input wire logic [31:0]             hrdata,
    input wire logic                    hreadyout,
    input wire logic                    hresp,
    input wire lcd_seg_pkg::lcd_drive_t lcd_drive,
    input wire lcd_seg_pkg::seg_gpio_t  seg_gpio
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic       taken;
    logic [3:0] com_full;
    logic       com_mid;
    logic       seg_mid;
    logic       seg_even;
    assign taken = hsel & htrans[1] & hready;
    always_comb
    begin
        com_mid  = 1'b0;
        seg_mid  = 1'b0;
        seg_even = 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            com_full[c] = lcd_drive.com[c] == 2'h3;
            com_mid     = com_mid | (lcd_drive.com[c] == 2'h2);
        end
        for (int s = 0; s < 40; s++)
        begin
            seg_mid  = seg_mid | (!seg_gpio.en[s] & (lcd_drive.seg[s] inside {2'h1, 2'h2}));
            seg_even = seg_even | (!seg_gpio.en[s] & !lcd_drive.seg[s][0]);
        end
    end
    chk_read_wait: assert property (taken & !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    chk_write_nowait: assert property (taken & hwrite |=> hreadyout)
        else $error("write stalled");
    chk_resp_okay: assert property (!hresp)
        else $error("error response");
    chk_rdata_hold: assert property ($changed(hrdata) |-> $past(taken & !hwrite, 2))
        else $error("read data moved");
    chk_one_full_com: assert property ($countones(com_full) <= 1)
        else $error("two commons at full");
    chk_half_com: assert property (lcd_drive.bias_half |-> !com_mid)
        else $error("third level on common");
    chk_half_seg: assert property (lcd_drive.bias_half |-> !seg_mid)
        else $error("mid level on segment");
    chk_seg_pair: assert property (com_mid |-> !seg_even)
        else $error("segment level wrong");
endmodule : lcd_seg_checker
bind lcd_segment_drive_controller lcd_seg_checker u_lcd_seg_checker (.sys_clk, .arst_n, .hsel, .htrans,
    .hwrite, .hready, .hrdata, .hreadyout, .hresp, .lcd_drive, .seg_gpio);
`default_nettype wire

// ==== dv/test_lcd_segment_drive_controller.sv ====
`default_nettype none
module test_lcd_segment_drive_controller;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, arst_n, hsel, hwrite, lcd_ext_clk, ext_run, clr, pol1, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [3:0][39:0] lit, acc, expv;
    logic [23:0][7:0] dm;
    int errors, comparisons, cycles;
    lcd_seg_pkg::lcd_drive_t lcd_drive;
    lcd_seg_pkg::seg_gpio_t seg_gpio;
    lcd_segment_drive_controller u_lcd_segment_drive_controller (.sys_clk(sys_clk), .arst_n(arst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .lcd_ext_clk(lcd_ext_clk), .lcd_drive(lcd_drive), .seg_gpio(seg_gpio));
    lcd_glass_model u_lcd_glass_model (.lcd_drive(lcd_drive), .lit(lit));
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        acc <= clr ? '0 : acc | lit;
        pol1 <= !clr & (pol1 | (lcd_drive.com[0] == 2'h3));
        if (ext_run)
            lcd_ext_clk <= ~lcd_ext_clk;
        if (cycles == 5000)
        begin
            errors++;
            end_sim();
        end
    end
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic check_vec(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check_vec
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        check_vec({8'h0, got}, {8'h0, exp});
    endtask : check_reg
    task automatic end_sim();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    initial
    begin
        {arst_n, hsel, hwrite, ext_run, lcd_ext_clk, clr, pol1} = '0;
        {htrans, haddr, hwdata, acc, dm, expv} = '0;
        hsize = 3'h2;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        for (int c = 0; c < 4; c++)
            for (int s = 0; s < 40; s++)
                if ((s + c) % 3 == 0)
                begin
                    expv[c][s] = 1'b1;
                    dm[c * 5 + s / 8][s % 8] = 1'b1;
                end
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check_vec(seg_gpio.en, 40'hffff000000);
        bus(1'b0, lcd_seg_pkg::REG_FDIV, '0);
        check_reg(q, 32'h000000ff);
        for (int z = 0; z < 3; z++)
        begin
            bus(1'b1, lcd_seg_pkg::REG_CTRL, z << 3);
            repeat (2) @(posedge sys_clk);
            check_vec(seg_gpio.en, ~40'h0 << (24 + 8 * z));
        end
        bus(1'b1, lcd_seg_pkg::REG_GPEN_LO, 32'h1);
        bus(1'b1, lcd_seg_pkg::REG_GPOUT_LO, 32'h1);
        repeat (2) @(posedge sys_clk);
        check_vec(seg_gpio.en, 40'h1);
        check_vec(seg_gpio.out, 40'h1);
        bus(1'b1, lcd_seg_pkg::REG_GPEN_LO, '0);
        bus(1'b1, 8'h1c, '1);
        bus(1'b0, 8'h1c, '0);
        check_reg(q, '0);
        bus(1'b1, lcd_seg_pkg::REG_DM_LAST, '1);
        bus(1'b0, lcd_seg_pkg::REG_DM_LAST, '0);
        check_reg(q, 32'h000000ff);
        for (int w = 0; w < 6; w++)
            bus(1'b1, lcd_seg_pkg::REG_DM_BASE + 8'(4 * w), dm[4 * w +: 4]);
        bus(1'b0, lcd_seg_pkg::REG_DM_BASE + 8'h4, '0);
        check_reg(q, dm[4 +: 4]);
        bus(1'b1, lcd_seg_pkg::REG_FDIV, 32'h2);
        for (int m = 0; m < 4; m++)
        begin
            clr <= 1'b1;
            bus(1'b1, lcd_seg_pkg::REG_CTRL, 32'h11 | (m << 1));
            clr <= 1'b0;
            repeat (6 * (m + 1) + 8) @(posedge sys_clk);
            for (int c = 0; c <= m; c++)
                check_vec(acc[c], expv[c]);
            check_vec(40'(pol1), 40'h1);
            check_vec(40'(lcd_drive.com >> (2 * (m + 1))), 40'h0);
            bus(1'b0, lcd_seg_pkg::REG_STATUS, '0);
            check_reg(32'(q[3]), 32'(m == 1));
            bus(1'b1, lcd_seg_pkg::REG_CTRL, 32'h10);
        end
        clr <= 1'b1;
        bus(1'b1, lcd_seg_pkg::REG_CTRL, 32'h37);
        clr <= 1'b0;
        repeat (30) @(posedge sys_clk);
        check_vec(acc[3], '0);
        ext_run <= 1'b1;
        repeat (80) @(posedge sys_clk);
        check_vec(acc[3], expv[3]);
        end_sim();
    end
endmodule : test_lcd_segment_drive_controller
`default_nettype wire
